/* File: core/sample_event_sequencer.v */
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "sequencer_regs.vh"
// Contract
// - start event when selected pacing condition met
// - time pacing: trigger when timer reaches interval
// - flow pacing: count pulses, trigger at total
// - move distributor to bottle before pumping
// - reverse pump for pre-sample purge
// - then pump forward until liquid detected
// - measure volume from detection until delivered
// - reverse for post purge, then pump off
// - rearm pacing, return to waiting
module sample_event_sequencer
#(
	parameter TICK_CYCLES = `TICK_CYCLES
)
(
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire flow_pulse,
	input wire liquid_detect,
	input wire dist_in_place,
	output reg dist_move,
	output reg [4:0] dist_bottle,
	output reg pump_fwd,
	output reg pump_rev,
	output wire busy
);
	// ****************************************************************
	// states of one sample event
	// ****************************************************************
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_MOVE = 3'h1;
	localparam [2:0] ST_PRE = 3'h2;
	localparam [2:0] ST_FILL = 3'h3;
	localparam [2:0] ST_DELIVER = 3'h4;
	localparam [2:0] ST_POST = 3'h5;

	// ****************************************************************
	// declarations
	// ****************************************************************
	reg enable; // pacing armed
	reg flow_mode; // 1 flow pacing, 0 time pacing
	reg [23:0] interval; // ticks between time-paced events
	reg [23:0] pulse_total; // pulses per flow-paced event
	reg [23:0] volume; // forward ticks after liquid detection
	reg [23:0] pre_purge; // reverse ticks before filling
	reg [23:0] post_purge; // reverse ticks after delivery
	reg [4:0] bottle_sel; // bottle for the next event
	reg [4:0] bottle_count; // bottles in the rack
	reg [23:0] pulse_cnt; // running flow pulse total
	reg [23:0] time_cnt; // ticks since rearm
	reg [23:0] phase_cnt; // ticks inside the current step
	reg [15:0] event_cnt; // completed events
	reg [2:0] state; // sequencer state
	reg [7:0] addr_q; // latched address phase
	reg wr_q; // write pending in data phase
	reg flow_d; // previous synced flow level
	reg [23:0] phase_limit; // length of the current timed step
	wire [2:0] pins_s; // synchronised pins
	wire flow_s;
	wire liquid_s;
	wire place_s;
	wire tick;
	wire flow_rise;
	wire time_hit;
	wire pulse_hit;
	wire start;
	wire phase_done;
	wire rearm;
	wire addr_ok;
	wire wr_ctrl;
	wire wr_bottle;
	wire [4:0] bottle_next;
	reg [31:0] next_rdata;

	// ****************************************************************
	// pin synchronisers and tick divider
	// ****************************************************************
	pin_sync u_sync
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.pin_in({dist_in_place, liquid_detect, flow_pulse}),
		.pin_sync_out(pins_s)
	);

	tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.tick(tick)
	);

	assign flow_s = pins_s[0];
	assign liquid_s = pins_s[1];
	assign place_s = pins_s[2];

	// ****************************************************************
	// ahb-lite slave: zero wait states, always okay
	// ****************************************************************
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_ok = hsel & hready & htrans[1];
	assign wr_ctrl = wr_q & (addr_q == `REG_CTRL);
	assign wr_bottle = wr_q & (addr_q == `REG_BOTTLE);

	// read mux, evaluated in the address phase so data come from a flop
	always @*
	begin
		next_rdata = 32'h00000000;
		case (haddr[7:0])
			`REG_CTRL: next_rdata = {30'h00000000, flow_mode, enable};
			`REG_INTERVAL: next_rdata = {8'h00, interval};
			`REG_PULSE_TOTAL: next_rdata = {8'h00, pulse_total};
			`REG_VOLUME: next_rdata = {8'h00, volume};
			`REG_PRE_PURGE: next_rdata = {8'h00, pre_purge};
			`REG_POST_PURGE: next_rdata = {8'h00, post_purge};
			`REG_BOTTLE: next_rdata = {19'h00000, bottle_count, 3'h0, bottle_sel};
			`REG_STATUS: next_rdata = {24'h000000, liquid_s, pump_rev, pump_fwd, dist_move, busy, state};
			`REG_PULSE_COUNT: next_rdata = {8'h00, pulse_cnt};
			`REG_EVENT_COUNT: next_rdata = {16'h0000, event_cnt};
			// unmapped offsets read zero
			default: next_rdata = 32'h00000000;
		endcase
	end

	// address phase capture and read data register
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			addr_q <= 8'h00;
			wr_q <= 1'b0;
			hrdata <= 32'h00000000;
		end
		else
		begin
			wr_q <= addr_ok & hwrite;
			if (addr_ok)
				addr_q <= haddr[7:0];
			if (addr_ok & ~hwrite)
				hrdata <= next_rdata;
		end
	end

	// software-written configuration, applied in the data phase
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			enable <= 1'b0;
			flow_mode <= 1'b0;
			interval <= `RST_INTERVAL;
			pulse_total <= `RST_PULSE_TOTAL;
			volume <= `RST_VOLUME;
			pre_purge <= `RST_PURGE;
			post_purge <= `RST_PURGE;
			bottle_count <= `RST_BOTTLE_COUNT;
		end
		else if (wr_q)
		begin
			case (addr_q)
				`REG_CTRL:
				begin
					enable <= hwdata[`CTRL_ENABLE];
					flow_mode <= hwdata[`CTRL_FLOW_MODE];
				end
				`REG_INTERVAL: interval <= hwdata[23:0];
				`REG_PULSE_TOTAL: pulse_total <= hwdata[23:0];
				`REG_VOLUME: volume <= hwdata[23:0];
				`REG_PRE_PURGE: pre_purge <= hwdata[23:0];
				`REG_POST_PURGE: post_purge <= hwdata[23:0];
				`REG_BOTTLE: bottle_count <= hwdata[`BOTTLE_COUNT_LSB+4:`BOTTLE_COUNT_LSB];
				// writes elsewhere are ignored
				default: enable <= enable;
			endcase
		end
	end

	// ****************************************************************
	// pacing: time interval and flow pulse total
	// ****************************************************************
	assign flow_rise = flow_s & ~flow_d;
	assign time_hit = (time_cnt >= interval);
	// a zero total would fire every cycle, so it disarms flow pacing
	assign pulse_hit = (pulse_total != 24'h000000) & (pulse_cnt >= pulse_total);
	assign start = enable & (state == ST_IDLE) & (flow_mode ? pulse_hit : time_hit);
	assign busy = (state != ST_IDLE);

	// flow pulses count in every state; start takes one total off, so
	// pulses seen during an event carry into the next interval
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			flow_d <= 1'b0;
			pulse_cnt <= 24'h000000;
		end
		else
		begin
			flow_d <= flow_s;
			if (start & flow_mode)
				pulse_cnt <= pulse_cnt - pulse_total + {23'h000000, flow_rise};
			else if (flow_rise)
				pulse_cnt <= pulse_cnt + 24'h000001;
		end
	end

	// interval timer: saturates at the interval, cleared when rearmed
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			time_cnt <= 24'h000000;
		else if (rearm)
			time_cnt <= 24'h000000;
		else if (tick & ~time_hit)
			time_cnt <= time_cnt + 24'h000001;
	end

	// ****************************************************************
	// timed steps: length of the step in progress
	// ****************************************************************
	always @*
	begin
		phase_limit = 24'h000000;
		case (state)
			ST_PRE: phase_limit = pre_purge;
			ST_DELIVER: phase_limit = volume;
			ST_POST: phase_limit = post_purge;
			default: phase_limit = 24'h000000;
		endcase
	end

	assign phase_done = (phase_cnt >= phase_limit);
	assign rearm = (state == ST_POST) & phase_done;
	assign bottle_next = (bottle_sel + 5'h01 >= bottle_count) ? 5'h00 : bottle_sel + 5'h01;

	// ****************************************************************
	// sample event sequencer
	// ****************************************************************
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state <= ST_IDLE;
			phase_cnt <= 24'h000000;
			dist_move <= 1'b0;
			dist_bottle <= 5'h00;
			pump_fwd <= 1'b0;
			pump_rev <= 1'b0;
		end
		else
		begin
			case (state)
				// idle: pump stopped, distributor left alone
				ST_IDLE:
				begin
					pump_fwd <= 1'b0;
					pump_rev <= 1'b0;
					phase_cnt <= 24'h000000;
					if (start)
					begin
						state <= ST_MOVE;
						dist_move <= 1'b1;
						dist_bottle <= bottle_sel;
					end
				end
				// wait for the arm to report the bottle reached
				ST_MOVE:
				begin
					if (place_s)
					begin
						dist_move <= 1'b0;
						pump_rev <= 1'b1;
						state <= ST_PRE;
					end
				end
				// air purge of the intake line
				ST_PRE:
				begin
					if (phase_done)
					begin
						pump_rev <= 1'b0;
						pump_fwd <= 1'b1;
						phase_cnt <= 24'h000000;
						state <= ST_FILL;
					end
					else if (tick)
						phase_cnt <= phase_cnt + 24'h000001;
				end
				// fill the line; no time limit, the detector must trip
				ST_FILL:
				begin
					phase_cnt <= 24'h000000;
					if (liquid_s)
						state <= ST_DELIVER;
				end
				// volume is measured only from the detector trip
				ST_DELIVER:
				begin
					if (phase_done)
					begin
						pump_fwd <= 1'b0;
						pump_rev <= 1'b1;
						phase_cnt <= 24'h000000;
						state <= ST_POST;
					end
					else if (tick)
						phase_cnt <= phase_cnt + 24'h000001;
				end
				// post purge, then pump off and wait again
				ST_POST:
				begin
					if (phase_done)
					begin
						pump_rev <= 1'b0;
						phase_cnt <= 24'h000000;
						state <= ST_IDLE;
					end
					else if (tick)
						phase_cnt <= phase_cnt + 24'h000001;
				end
				default:
				begin
					state <= ST_IDLE;
					dist_move <= 1'b0;
					pump_fwd <= 1'b0;
					pump_rev <= 1'b0;
				end
			endcase
		end
	end

	// bottle pointer and event count; the advance at the end of an
	// event wins over a software write in the same cycle
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bottle_sel <= 5'h00;
			event_cnt <= 16'h0000;
		end
		else if (rearm)
		begin
			bottle_sel <= bottle_next;
			event_cnt <= event_cnt + 16'h0001;
		end
		else if (wr_bottle)
			bottle_sel <= hwdata[`BOTTLE_SEL_LSB+4:`BOTTLE_SEL_LSB];
	end
endmodule

/* File: core/sequencer_regs.vh */
`ifndef SEQUENCER_REGS_VH
`define SEQUENCER_REGS_VH
// ****************************************************************
// register offsets (byte addresses, one word each)
// ****************************************************************
`define REG_CTRL 8'h00
`define REG_INTERVAL 8'h04
`define REG_PULSE_TOTAL 8'h08
`define REG_VOLUME 8'h0C
`define REG_PRE_PURGE 8'h10
`define REG_POST_PURGE 8'h14
`define REG_BOTTLE 8'h18
`define REG_STATUS 8'h1C
`define REG_PULSE_COUNT 8'h20
`define REG_EVENT_COUNT 8'h24
// ****************************************************************
// field positions and widths
// ****************************************************************
`define CTRL_ENABLE 0
`define CTRL_FLOW_MODE 1
`define BOTTLE_SEL_LSB 0
`define BOTTLE_COUNT_LSB 8
`define BOTTLE_W 5
`define CNT_W 24
`define STATE_W 3
// ****************************************************************
// reset values
// ****************************************************************
`define RST_INTERVAL 24'h00003C
`define RST_PULSE_TOTAL 24'h00000A
`define RST_VOLUME 24'h000064
`define RST_PURGE 24'h00000A
`define RST_BOTTLE_COUNT 5'h18
// ****************************************************************
// timing: one pacing tick, in microseconds, and the clock rate
// ****************************************************************
`define TICK_US 1000
`define CLK_MHZ 20
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`endif

/* File: core/pin_sync.v */
`timescale 1ns/1ps
// ****************************************************************
// two-stage synchroniser for a group of pin inputs
// ****************************************************************
module pin_sync
(
	input wire hclk,
	input wire hresetn,
	input wire [2:0] pin_in,
	output reg [2:0] pin_sync_out
);
	reg [2:0] meta; // first stage, read only by the second stage

	// both stages start at zero, no pin is seen during reset
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			meta <= 3'h0;
			pin_sync_out <= 3'h0;
		end
		else
		begin
			meta <= pin_in;
			pin_sync_out <= meta;
		end
	end
endmodule

/* File: core/tick_gen.v */
`timescale 1ns/1ps
// ****************************************************************
// free-running divider giving one pacing tick pulse
// ****************************************************************
module tick_gen
#(
	parameter TICK_CYCLES = 20000
)
(
	input wire hclk,
	input wire hresetn,
	output reg tick
);
	// the count is worked out at full width, then cut to the divider on purpose
	localparam [31:0] LAST_WIDE = TICK_CYCLES - 1;
	localparam [15:0] LAST = LAST_WIDE[15:0];
	reg [15:0] div; // cycles since the last tick

	// tick is a one-cycle pulse every TICK_CYCLES clocks
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div <= 16'h0000;
			tick <= 1'b0;
		end
		else if (div >= LAST)
		begin
			div <= 16'h0000;
			tick <= 1'b1;
		end
		else
		begin
			div <= div + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule

/* File: tb/seq_props.sv */
`timescale 1ns/1ps
// ********
// sequencer output checks
// ********
module seq_props
(
	input wire hclk,
	input wire hresetn,
	input wire liquid_detect,
	input wire dist_in_place,
	input wire dist_move,
	input wire [4:0] dist_bottle,
	input wire pump_fwd,
	input wire pump_rev,
	input wire busy
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// pin dry since before forward pumping began; sync delay covered
	sequence dry_fill;
		(!liquid_detect)[*2] ##1 ($rose(pump_fwd) && !liquid_detect) ##1 (!liquid_detect)[*3];
	endsequence
	// distributor requested but not yet reported in place
	sequence parked_move;
		(dist_move && !dist_in_place)[*4];
	endsequence
	a_pump_exclusive: assert property (!(pump_fwd && pump_rev))
		else $error("pump driven both ways");
	a_idle_quiet: assert property (!busy |-> !(pump_fwd || pump_rev || dist_move))
		else $error("activity while idle");
	a_move_first: assert property ($rose(busy) |-> dist_move && !pump_fwd && !pump_rev)
		else $error("event did not open with a move");
	a_purge_after_move: assert property ($fell(dist_move) |-> pump_rev && busy)
		else $error("no reverse purge after move");
	a_fwd_after_purge: assert property ($fell(pump_rev) && busy |-> pump_fwd)
		else $error("no forward after purge");
	a_rev_after_fwd: assert property ($fell(pump_fwd) |-> pump_rev)
		else $error("no post purge after delivery");
	a_dry_keeps_fwd: assert property (dry_fill |-> pump_fwd)
		else $error("forward stopped before liquid");
	a_move_holds: assert property (parked_move |=> dist_move)
		else $error("move dropped before in place");
	a_bottle_held: assert property (busy && !$rose(busy) |-> $stable(dist_bottle))
		else $error("target bottle changed mid-event");
endmodule
bind sample_event_sequencer seq_props chk
(
	.hclk(hclk),
	.hresetn(hresetn),
	.liquid_detect(liquid_detect),
	.dist_in_place(dist_in_place),
	.dist_move(dist_move),
	.dist_bottle(dist_bottle),
	.pump_fwd(pump_fwd),
	.pump_rev(pump_rev),
	.busy(busy)
);

/* File: tb/flow_meter.sv */
`timescale 1ns/1ps
// ********
// flow meter: one pulse per flow quantity passed
// ********
module flow_meter
(
	input wire hclk,
	input wire [7:0] quantities,
	input wire slow,
	output reg flow_pulse
);
	reg [7:0] sent = 8'h00; // quantities already signalled
	reg [3:0] phase = 4'h0; // cycles left in current pulse
	initial flow_pulse = 1'b0;
	// pulses stay wide enough for the two-flop sync
	always @(posedge hclk)
	begin
		if (phase != 4'h0)
			phase <= phase - 4'h1;
		else if (sent != quantities)
		begin
			sent <= sent + 8'h01;
			phase <= slow ? 4'hA : 4'h5;
		end
		flow_pulse <= phase > (slow ? 4'h6 : 4'h3);
	end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
// ********
// sequencer bench
// ********
module testbench;
	localparam TC = 4; // short tick keeps runs brief
	reg hclk, hresetn, hsel, hwrite, liquid_detect, dist_in_place, slow;
	reg [31:0] haddr, hwdata, q;
	reg [1:0] htrans;
	reg [7:0] flow_qty;
	integer seed = 32'h97248F80;
	integer err_total = 0, samples_checked = 0, wet = 0, extra = 0;
	integer i, k, n, vol, iv, tot, carry, gap, eb;
	time tf = 0; // moment the last event ended
	wire hreadyout, hresp, dist_move, pump_fwd, pump_rev, busy, flow_pulse;
	wire [31:0] hrdata;
	wire [4:0] dist_bottle;
	sample_event_sequencer #(.TICK_CYCLES(TC)) dut
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(3'h2),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.flow_pulse(flow_pulse),
		.liquid_detect(liquid_detect),
		.dist_in_place(dist_in_place),
		.dist_move(dist_move),
		.dist_bottle(dist_bottle),
		.pump_fwd(pump_fwd),
		.pump_rev(pump_rev),
		.busy(busy)
	);
	flow_meter meter
	(
		.hclk(hclk),
		.quantities(flow_qty),
		.slow(slow),
		.flow_pulse(flow_pulse)
	);
	always #25 hclk = ~hclk;
	// distributor and detector react at random delays; low while idle
	always @(posedge hclk)
	begin
		if (!busy)
		begin
			dist_in_place <= 1'b0;
			liquid_detect <= 1'b0;
		end
		else
		begin
			if (dist_move && $random(seed) % 3 == 0)
				dist_in_place <= 1'b1;
			if (pump_fwd && $random(seed) % 4 == 0)
				liquid_detect <= 1'b1;
		end
	end
	// forward time after the detector trips is the programmed volume
	always @(posedge hclk)
	begin
		if (pump_fwd && liquid_detect)
			wet = wet + 1;
		else if (wet > 0)
		begin
			check("deliver", 1, wet >= vol * TC && wet <= vol * TC + TC + 4);
			wet = 0;
		end
	end
	task give_verdict;
		begin
			$display("checked %0d errors %0d", samples_checked, err_total);
			if (err_total == 0 && samples_checked > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task check(input string nm, input [31:0] e, input [31:0] g);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e)
			begin
				err_total = err_total + 1;
				$display("[FAIL] %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// one bounded clock step; a hang ends the run
	task step;
		begin
			n = n + 1;
			if (n > 3000)
			begin
				err_total = err_total + 1;
				give_verdict;
			end
			@(posedge hclk);
		end
	endtask
	task bus(input w, input [7:0] a, input [31:0] d);
		begin
			hsel <= 1'b1;
			htrans <= 2'h2;
			hwrite <= w;
			haddr <= {24'h000000, a};
			n = 0;
			step;
			while (hreadyout !== 1'b1)
				step;
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= d;
			n = 0;
			step;
			while (hreadyout !== 1'b1)
				step;
			q = hrdata;
		end
	endtask
	// one whole event; extra flow arrives while it runs
	task event_run;
		begin
			n = 0;
			while (busy !== 1'b1)
				step;
			gap = ($time - tf) / 50;
			check("bottle", eb, dist_bottle);
			// still moving: busy and move bits set, pumps off, state move
			bus(0, 8'h1C, 0);
			check("status in move", 32'h19, q);
			flow_qty <= flow_qty + extra;
			n = 0;
			while (busy !== 1'b0)
				step;
			tf = $time;
			eb = (eb + 1) % 5;
		end
	endtask
	function [31:0] rst_val(input integer r);
		case (r)
			1: rst_val = 32'h3C;
			2, 4, 5: rst_val = 32'h0A;
			3: rst_val = 32'h64;
			6: rst_val = 32'h1800;
			default: rst_val = 32'h0;
		endcase
	endfunction
	initial
	begin
		{hclk, hresetn, hsel, hwrite, liquid_detect, dist_in_place, slow} = 7'h00;
		{haddr, hwdata, htrans, flow_qty} = 74'h0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		// reset table, status idle, unmapped word reads zero
		for (i = 0; i < 11; i = i + 1)
		begin
			bus(0, {i[5:0], 2'h0}, 0);
			check("reset value", rst_val(i), q);
			check("bus response", 0, hresp);
		end
		vol = 1 + {$random(seed)} % 3;
		iv = 3 + {$random(seed)} % 3;
		bus(1, 8'h04, iv);
		bus(1, 8'h0C, vol);
		bus(1, 8'h10, {$random(seed)} % 3);
		bus(1, 8'h14, {$random(seed)} % 3);
		bus(1, 8'h18, 32'h0503);
		eb = 3;
		bus(1, 8'h00, 1);
		// time pacing: idle gap restarts from zero each event
		for (k = 0; k < 3; k = k + 1)
		begin
			event_run;
			if (k > 0)
				check("gap", 1, gap >= (iv - 1) * TC && gap <= iv * TC + 3);
		end
		bus(1, 8'h00, 0);
		bus(0, 8'h24, 0);
		check("events", 3, q);
		// flow pacing: one short of the total must not start
		tot = 2 + {$random(seed)} % 3;
		bus(1, 8'h08, tot);
		bus(1, 8'h00, 3);
		carry = 0;
		for (k = 0; k < 2; k = k + 1)
		begin
			slow <= ~slow;
			extra = 1 + {$random(seed)} % (tot - 1);
			flow_qty <= flow_qty + tot - carry - 1;
			repeat (80) @(posedge hclk);
			check("early start", 0, busy);
			flow_qty <= flow_qty + 8'h01;
			event_run;
			repeat (80) @(posedge hclk);
			bus(0, 8'h20, 0);
			check("carried pulses", extra, q);
			carry = extra;
		end
		give_verdict;
	end
endmodule
